// ---- osm_output_selector.v ----
// Output selector routing demodulator signals onto buses A and B, plus snapshot command
//
// Contract
// - Code 0000 puts I/Q soft bits and status 6..3 on A, status 2..0 and AGC 7..1 on B.
// - Code 0001 puts both soft signs and magnitude on A, status 6, status 0 and phase on B.
// - Code 0010 keeps the 0000 layout on A and puts status 2..0 and frequency error 7..1 on B.
// - Code 0011 keeps the 0000 layout on A and puts status 2..0 and gain error 7..1 on B.
// - Code 0100 keeps the 0000 layout on A and puts status 2..0 and timing error 7..1 on B.
// - Code 0101 keeps the 0000 layout on A and puts status 2..0 and carrier error 7..1 on B.
// - Code 0110 puts soft bits and lock accumulator 6..3 on A, lock acc 2..0 and count on B.
// - Code 0111 puts soft bits and I end 7..4 on A, I end 3..1 and Q end 7..1 on B.
// - Code 1000 puts the NCO cosine on B, zero in A 9..2, status 5 in A1 and status 6 in A0.
// - Writing destination 29 samples carrier lag, symbol lag and AGC accumulators to holding.
// - Error words on the buses follow the symbol rate, not processor reads.
// - Each soft decision is three bits, sign on top, in the format a config bit picks.
// - Lock accumulator output shows bits 13..7 only when bits 17..14 are all one, else zero.
// - Lock count output shows bits 6..0 only when bits 9..7 are zero, else zero.
// - In codes 0010 to 0101, status 0 pulses one clock together with each new value on bus B's field.
`include "osm_regs.vh"
module osm_output_selector #(
    parameter ACC_W = 32,
    parameter AGC_W = 8
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    // Processor destination-address write port
    input wire wr_en_i,
    input wire [4:0] wr_addr_i,
    input wire [7:0] wr_data_i,
    // Upstream datapath, same clock
    input wire soft_offset_fmt_i,
    input wire [2:0] i_soft_decision_i,
    input wire [2:0] q_soft_decision_i,
    input wire [6:0] status_i,
    input wire [7:0] agc_accum_i,
    input wire [7:0] amplitude_polar_i,
    input wire [7:0] phase_polar_i,
    input wire [7:0] freq_error_word_i,
    input wire [7:0] gain_error_word_i,
    input wire [7:0] timing_error_word_i,
    input wire [7:0] carrier_phase_error_i,
    input wire symbol_strobe_i,
    input wire [17:0] lock_phase_accum_i,
    input wire [9:0] lock_integration_count_i,
    input wire [7:0] i_end_sample_i,
    input wire [7:0] q_end_sample_i,
    input wire [9:0] oscillator_cosine_i,
    input wire [ACC_W-1:0] carrier_lag_accum_i,
    input wire [ACC_W-1:0] symbol_lag_accum_i,
    input wire [AGC_W-1:0] agc_full_accum_i,
    // Outputs
    output reg [9:0] output_bus_a_o,
    output reg [9:0] output_bus_b_o,
    output reg data_ready_o,
    output reg [3:0] route_select_o,
    output wire [ACC_W-1:0] carrier_lag_hold_o,
    output wire [ACC_W-1:0] symbol_lag_hold_o,
    output wire [AGC_W-1:0] agc_hold_o,
    output wire snapshot_busy_o
);
    // ==========================================================
    // Destination-address decode
    reg [3:0] sel_r;
    wire snap_take;
    assign snap_take = wr_en_i && (wr_addr_i == `OSM_ADDR_SNAPSHOT_HOLDING_UPDATE);
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_r <= `OSM_SEL_RESET;
        end else if (wr_en_i && (wr_addr_i == `OSM_ADDR_OUTPUT_ROUTE_SELECT)) begin
            sel_r <= wr_data_i[`OSM_SEL_MSB:`OSM_SEL_LSB];
        end
    end
    // ==========================================================
    // Symbol-rate error word latches
    reg [7:0] fe_r;
    reg [7:0] ge_r;
    reg [7:0] te_r;
    reg [7:0] pe_r;
    reg sym_d_r;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fe_r <= 8'h00;
            ge_r <= 8'h00;
            te_r <= 8'h00;
            pe_r <= 8'h00;
            sym_d_r <= 1'b0;
        end else begin
            sym_d_r <= symbol_strobe_i;
            if (symbol_strobe_i) begin
                fe_r <= freq_error_word_i;
                ge_r <= gain_error_word_i;
                te_r <= timing_error_word_i;
                pe_r <= carrier_phase_error_i;
            end
        end
    end
    // ==========================================================
    // Soft decision format and lock detector gating
    wire [2:0] i_soft_decision;
    wire [2:0] q_soft_decision;
    wire [6:0] lock_phase_accum;
    wire [6:0] lock_integration_count;
    // Offset-binary format inverts the sign bit only
    assign i_soft_decision = {i_soft_decision_i[2] ^ soft_offset_fmt_i, i_soft_decision_i[1:0]};
    assign q_soft_decision = {q_soft_decision_i[2] ^ soft_offset_fmt_i, q_soft_decision_i[1:0]};
    assign lock_phase_accum = (&lock_phase_accum_i[17:14]) ? lock_phase_accum_i[13:7] : 7'h00;
    assign lock_integration_count = (lock_integration_count_i[9:7] == 3'h0) ?
        lock_integration_count_i[6:0] : 7'h00;
    // ==========================================================
    // Bus routing
    reg [9:0] a_nxt;
    reg [9:0] b_nxt;
    reg rdy_nxt;
    wire [9:0] a_std;
    assign a_std = {i_soft_decision, q_soft_decision, status_i[6:3]};
    always @* begin
        a_nxt = 10'h000;
        b_nxt = 10'h000;
        rdy_nxt = 1'b0;
        case (sel_r)
            `OSM_SEL_AGC: begin
                a_nxt = a_std;
                b_nxt = {status_i[2:0], agc_accum_i[7:1]};
            end
            `OSM_SEL_POLAR: begin
                a_nxt = {i_soft_decision[2], q_soft_decision[2], amplitude_polar_i};
                b_nxt = {status_i[6], status_i[0], phase_polar_i};
            end
            `OSM_SEL_FREQ: begin
                a_nxt = a_std;
                b_nxt = {status_i[2:0], fe_r[7:1]};
                rdy_nxt = sym_d_r;
            end
            `OSM_SEL_GAIN: begin
                a_nxt = a_std;
                b_nxt = {status_i[2:0], ge_r[7:1]};
                rdy_nxt = sym_d_r;
            end
            `OSM_SEL_TIMING: begin
                a_nxt = a_std;
                b_nxt = {status_i[2:0], te_r[7:1]};
                rdy_nxt = sym_d_r;
            end
            `OSM_SEL_CARRIER: begin
                a_nxt = a_std;
                b_nxt = {status_i[2:0], pe_r[7:1]};
                rdy_nxt = sym_d_r;
            end
            `OSM_SEL_LOCK: begin
                a_nxt = {i_soft_decision, q_soft_decision, lock_phase_accum[6:3]};
                b_nxt = {lock_phase_accum[2:0], lock_integration_count};
            end
            `OSM_SEL_ENDSAMP: begin
                a_nxt = {i_soft_decision, q_soft_decision, i_end_sample_i[7:4]};
                b_nxt = {i_end_sample_i[3:1], q_end_sample_i[7:1]};
            end
            `OSM_SEL_NCO: begin
                a_nxt = {8'h00, status_i[5], status_i[6]};
                b_nxt = oscillator_cosine_i;
            end
            default: begin
                a_nxt = 10'h000;
                b_nxt = 10'h000;
            end
        endcase
    end
    // Status 0 on the bus marks the freshly latched error word
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_bus_a_o <= 10'h000;
            output_bus_b_o <= 10'h000;
            data_ready_o <= 1'b0;
            route_select_o <= `OSM_SEL_RESET;
        end else begin
            output_bus_a_o <= a_nxt;
            if (sel_r == `OSM_SEL_POLAR) begin
                output_bus_b_o <= b_nxt;
            end else if (sel_r >= `OSM_SEL_FREQ && sel_r <= `OSM_SEL_CARRIER) begin
                output_bus_b_o <= {b_nxt[9:8], rdy_nxt, b_nxt[6:0]};
            end else begin
                output_bus_b_o <= b_nxt;
            end
            data_ready_o <= rdy_nxt;
            route_select_o <= sel_r;
        end
    end
    // ==========================================================
    // Snapshot holding registers
    wire busy_c;
    osm_snap_hold #(.WIDTH(ACC_W), .STAGES(`OSM_SNAP_STAGES)) u_hold_carrier (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .take_i(snap_take),
        .src_i(carrier_lag_accum_i),
        .hold_o(carrier_lag_hold_o),
        .busy_o(busy_c)
    );
    osm_snap_hold #(.WIDTH(ACC_W), .STAGES(`OSM_SNAP_STAGES)) u_hold_symbol (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .take_i(snap_take),
        .src_i(symbol_lag_accum_i),
        .hold_o(symbol_lag_hold_o),
        .busy_o()
    );
    osm_snap_hold #(.WIDTH(AGC_W), .STAGES(`OSM_SNAP_STAGES)) u_hold_agc (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .take_i(snap_take),
        .src_i(agc_full_accum_i),
        .hold_o(agc_hold_o),
        .busy_o()
    );
    assign snapshot_busy_o = busy_c;
endmodule

// ---- osm_output_selector_monitor.sv ----
// Port assertions for the output selector
module osm_sel_monitor #(
    parameter ACC_W = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [4:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [6:0] status_i,
    input wire logic [7:0] agc_accum_i,
    input wire logic [7:0] freq_error_word_i,
    input wire logic symbol_strobe_i,
    input wire logic [9:0] oscillator_cosine_i,
    input wire logic [ACC_W-1:0] carrier_lag_accum_i,
    input wire logic [9:0] output_bus_a_o,
    input wire logic [9:0] output_bus_b_o,
    input wire logic data_ready_o,
    input wire logic [3:0] route_select_o,
    input wire logic [ACC_W-1:0] carrier_lag_hold_o,
    input wire logic snapshot_busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence snap_cmd_s;
        wr_en_i && wr_addr_i == 5'h1D;
    endsequence
    // Select register stays put from the cycle before the strobe on
    sequence strobe_s;
        !wr_en_i ##1 symbol_strobe_i && route_select_o == 4'h2 && !wr_en_i;
    endsequence
    sel_write_a: assert property (
        wr_en_i && wr_addr_i == 5'h1C |-> ##2 route_select_o == $past(wr_data_i[3:0], 2))
        else $error("selection code not loaded");
    // Route copy and buses leave the same edge
    agc_route_a: assert property (
        route_select_o == 4'h0 && $past(rst_n_i) |->
        output_bus_b_o == {$past(status_i[2:0]), $past(agc_accum_i[7:1])})
        else $error("code 0 bus B wrong");
    nco_route_a: assert property (
        route_select_o == 4'h8 |-> {output_bus_a_o, output_bus_b_o} ==
        {8'h00, $past(status_i[5]), $past(status_i[6]), $past(oscillator_cosine_i)})
        else $error("code 8 buses wrong");
    ready_pulse_a: assert property (
        strobe_s |-> ##2 data_ready_o &&
        output_bus_b_o[6:0] == $past(freq_error_word_i[7:1], 2))
        else $error("ready pulse or error word missing");
    ready_cause_a: assert property (data_ready_o |-> $past(symbol_strobe_i, 2))
        else $error("ready pulse without symbol strobe");
    unused_code_a: assert property (
        route_select_o > 4'h8 |-> output_bus_a_o == 10'h000 && output_bus_b_o == 10'h000)
        else $error("unused code drives buses");
    snap_hold_a: assert property (
        snap_cmd_s |-> ##6 carrier_lag_hold_o == $past(carrier_lag_accum_i, 6))
        else $error("holding register not sampled");
    snap_busy_a: assert property (snap_cmd_s |=> snapshot_busy_o [*5])
        else $error("snapshot busy window wrong");
endmodule
bind osm_output_selector osm_sel_monitor #(.ACC_W(ACC_W)) u_mon (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .status_i(status_i),
    .agc_accum_i(agc_accum_i),
    .freq_error_word_i(freq_error_word_i),
    .symbol_strobe_i(symbol_strobe_i),
    .oscillator_cosine_i(oscillator_cosine_i),
    .carrier_lag_accum_i(carrier_lag_accum_i),
    .output_bus_a_o(output_bus_a_o),
    .output_bus_b_o(output_bus_b_o),
    .data_ready_o(data_ready_o),
    .route_select_o(route_select_o),
    .carrier_lag_hold_o(carrier_lag_hold_o),
    .snapshot_busy_o(snapshot_busy_o)
);

// ---- osm_regs.vh ----
// Register offsets, field positions, reset values and timing counts of the output selector
`ifndef OSM_REGS_VH
`define OSM_REGS_VH
// Destination addresses
`define OSM_ADDR_OUTPUT_ROUTE_SELECT 5'h1C
`define OSM_ADDR_SNAPSHOT_HOLDING_UPDATE 5'h1D
// Field layout of output_route_select
`define OSM_SEL_MSB 3
`define OSM_SEL_LSB 0
`define OSM_SEL_RESET 4'h0
// Selection codes
`define OSM_SEL_AGC 4'h0
`define OSM_SEL_POLAR 4'h1
`define OSM_SEL_FREQ 4'h2
`define OSM_SEL_GAIN 4'h3
`define OSM_SEL_TIMING 4'h4
`define OSM_SEL_CARRIER 4'h5
`define OSM_SEL_LOCK 4'h6
`define OSM_SEL_ENDSAMP 4'h7
`define OSM_SEL_NCO 4'h8
// Snapshot settle time in clocks
`define OSM_SNAP_SETTLE_CLKS 6
`define OSM_SNAP_STAGES 5
`endif

// ---- osm_sink_model.sv ----
// Downstream monitor latching the bus B error field on each ready strobe
module osm_sink_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic data_ready_i,
    input wire logic [9:0] bus_b_i,
    output logic [6:0] word_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_o <= 7'h00;
        end else if (data_ready_i) begin
            word_o <= bus_b_i[6:0];
        end
    end
endmodule

// ---- osm_snap_hold.v ----
// Holding register that samples one accumulator after a pipelined delay
module osm_snap_hold #(
    parameter WIDTH = 32,
    parameter STAGES = 5
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire take_i,
    input wire [WIDTH-1:0] src_i,
    output reg [WIDTH-1:0] hold_o,
    output reg busy_o
);
    reg [WIDTH-1:0] pipe_r [0:STAGES-1];
    reg [STAGES-1:0] vld_r;
    integer k;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (k = 0; k < STAGES; k = k + 1) begin
                pipe_r[k] <= {WIDTH{1'b0}};
            end
            vld_r <= {STAGES{1'b0}};
            hold_o <= {WIDTH{1'b0}};
            busy_o <= 1'b0;
        end else begin
            pipe_r[0] <= src_i;
            vld_r[0] <= take_i;
            for (k = 1; k < STAGES; k = k + 1) begin
                pipe_r[k] <= pipe_r[k-1];
                vld_r[k] <= vld_r[k-1];
            end
            if (vld_r[STAGES-1] && !take_i) begin
                hold_o <= pipe_r[STAGES-1];
            end else if (vld_r[STAGES-1]) begin
                hold_o <= pipe_r[STAGES-1];
            end
            busy_o <= take_i | (|vld_r[STAGES-2:0]);
        end
    end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the output selector
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 0, rst_n_i = 0, wr_en_i = 0, strb = 0, fmt = 0, rdy, busy;
    logic [4:0] wr_addr_i = 0;
    logic [7:0] wr_data_i = 0, ew = 8'hA5, v = 8'h6B, agc = 8'hC3, hg;
    logic [6:0] st = 7'h5B, mw;
    logic [17:0] lk = 18'h3D5AB;
    logic [9:0] cnt = 10'h055, nco = 10'h2C3, ba, bb;
    logic [31:0] cl = 32'h12345678, sl = 32'h9ABCDEF0, hc, hs;
    int err_count = 0, checks = 0;
    osm_output_selector dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .soft_offset_fmt_i(fmt),
        .i_soft_decision_i(v[2:0]), .q_soft_decision_i(v[5:3]), .status_i(st),
        .agc_accum_i(agc), .amplitude_polar_i(v), .phase_polar_i(~v),
        .freq_error_word_i(ew), .gain_error_word_i(ew + 8'h02),
        .timing_error_word_i(ew + 8'h04), .carrier_phase_error_i(ew + 8'h06),
        .symbol_strobe_i(strb), .lock_phase_accum_i(lk), .lock_integration_count_i(cnt),
        .i_end_sample_i(v), .q_end_sample_i(~v), .oscillator_cosine_i(nco),
        .carrier_lag_accum_i(cl), .symbol_lag_accum_i(sl), .agc_full_accum_i(agc),
        .output_bus_a_o(ba), .output_bus_b_o(bb), .data_ready_o(rdy), .route_select_o(),
        .carrier_lag_hold_o(hc), .symbol_lag_hold_o(hs), .agc_hold_o(hg),
        .snapshot_busy_o(busy));
    osm_sink_model sink (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .data_ready_i(rdy),
        .bus_b_i(bb), .word_o(mw));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // Expected bus pair per code, ready bit low
    function automatic logic [19:0] exp_ab(input logic [3:0] c);
        logic [2:0] is, qs;
        logic [6:0] la, lc;
        logic [7:0] e;
        is = v[2:0] ^ {fmt, 2'b00};
        qs = v[5:3] ^ {fmt, 2'b00};
        la = (&lk[17:14]) ? lk[13:7] : 7'h00;
        lc = (cnt[9:7] == 3'h0) ? cnt[6:0] : 7'h00;
        e = ew + {3'h0, c - 4'h2, 1'b0};
        case (c)
            4'h0: return {is, qs, st[6:3], st[2:0], agc[7:1]};
            4'h1: return {is[2], qs[2], v, st[6], st[0], ~v};
            4'h2, 4'h3, 4'h4, 4'h5: return {is, qs, st[6:3], st[2:1], 1'b0, e[7:1]};
            4'h6: return {is, qs, la, lc};
            4'h7: return {is, qs, v[7:1], ~v[7:1]};
            4'h8: return {8'h00, st[5], st[6], nco};
            default: return 20'h00000;
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wr_addr_i = a;
        wr_data_i = d;
        wr_en_i = 1;
        tick(1);
        wr_en_i = 0;
        tick(1);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_routes();
        strb = 1;
        tick(1);
        strb = 0;
        for (int f = 0; f < 2; f++) begin
            fmt = f[0];
            for (int c = 0; c < 11; c++) begin
                wr(5'h1C, (c == 10) ? 8'hFF : 8'(c));
                tick(2);
                `CHK({ba, bb}, exp_ab(wr_data_i[3:0]))
            end
        end
        $display("routes done");
    endtask
    task automatic t_strobe();
        logic [19:0] x;
        for (int c = 2; c < 6; c++) begin
            wr(5'h1C, 8'(c));
            ew = ew + 8'h36;
            x = exp_ab(4'(c));
            strb = 1;
            tick(1);
            strb = 0;
            `CHK(rdy, 1'b0)
            tick(1);
            `CHK({rdy, bb}, {1'b1, x[9:0] | 10'h080})
            tick(1);
            `CHK({rdy, mw}, {1'b0, x[6:0]})
        end
        $display("strobe done");
    endtask
    task automatic t_lock();
        lk = 18'h1D5AB;
        cnt = 10'h0D5;
        wr(5'h1C, 8'h06);
        tick(2);
        `CHK({ba, bb}, exp_ab(4'h6))
        $display("lock done");
    endtask
    task automatic t_snap();
        logic [71:0] old;
        old = {cl, sl, agc};
        wr(5'h1D, 8'h00);
        {cl, sl, agc} = ~old;
        tick(3);
        `CHK({busy, hc}, {1'b1, 32'h0})
        tick(1);
        `CHK({busy, hc, hs, hg}, {1'b0, old})
        $display("snapshot done");
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        err_count++;
        conclude();
    end
    initial begin
        tick(3);
        `CHK({ba, bb, rdy, busy}, 22'h0)
        rst_n_i = 1;
        t_routes();
        t_strobe();
        t_lock();
        t_snap();
        conclude();
    end
endmodule
